/* design/mscfg_regs.sv */
// What this block does
// - Bit 0 inverts colour table addressing on host access; resets 0.
// - Bits 2:1 hold triangle iterator mode, reset zero.
// - Board vendor/system ident writes pass only while bit 3 is set.
// - Expansion ROM window writes reach the ROM only while bit 4 set.
// - Bit 5 selects the compact alternate triangle address map.
// - Bit 6 disables texture mapping.
// - Bits 11:7 power down colour table, DAC, video, graphics, memory PLL.
// - Bits 14:12 block-write threshold; bit 15 disables 2D block writes.
// - Bit 19 halts the command FIFO and resets command registers.
// - Bits 28:24 load straps at boot and stay writable for reporting.
// - Straps 0..4 feed fast PCI, BIOS size, 66 MHz, AGP, device type.
// - SGRAM timing register resets to 0x00579D29.
// - Two-bit fields give value plus one clocks for RRD, RCD, RP, CAS.
// - Row active and row cycle minimums are value plus one, 1 to 16.
// - Single-bit fields give value plus one; read-to-mask given directly.
// - Block write to precharge waits value plus one clocks, 1 to 4.
// - Bit 23 ends reads with burst terminate instead of write cut.
// - A turnaround cycle sits between read and write unless bit 24 set.
// - Bit 25 enables SGRAM per-bit write masking.
// - Bit 26 chip set count, bit 27 density; reset from straps 5, 6.
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module mscfg_regs
	import mscfg_pkg::*;
(
	input  wire logic               hclk,
	input  wire logic               hresetn,
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output var  logic               hreadyout,
	output var  logic               hresp,
	output var  logic [31:0]        hrdata,
	input  wire logic [STRAP_W-1:0] strap_data_input,
	input  wire logic               board_ident_wr_req,
	input  wire logic               rom_wr_req,
	output var  logic               board_ident_wr_en,
	output var  logic               rom_wr_en,
	output var  mscfg_misc_t        misc_ctrl,
	output var  mscfg_sgram_t       sgram_timing
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic        ap_write;
		logic [1:0]  ap_sel;
		logic [31:0] misc;
		logic [31:0] sgram;
		logic [31:0] rdata;
		logic        id_en;
		logic        rom_en;
	} mscfg_st_t;

	localparam logic [1:0] SEL_NONE  = 2'h0;
	localparam logic [1:0] SEL_MISC  = 2'h1;
	localparam logic [1:0] SEL_SGRAM = 2'h2;

	mscfg_st_t          st_q;
	mscfg_st_t          st_d;
	logic [STRAP_W-1:0] strap_val;
	logic               strap_load;
	logic               take;
	logic [1:0]         sel_dec;

	// ****************************************
	// Strap capture
	// ****************************************
	mscfg_strap u_strap (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.strap_in (strap_data_input),
		.strap_q  (strap_val),
		.load_q   (strap_load)
	);

	// Address phase decode
	assign take = hsel && hready && htrans[1];

	always_comb begin
		sel_dec = SEL_NONE;
		if (haddr[7:0] == MISC_OFS) begin
			sel_dec = SEL_MISC;
		end else if (haddr[7:0] == SGRAM_OFS) begin
			sel_dec = SEL_SGRAM;
		end
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		st_d = st_q;
		// Data phase write, masked so reserved bits stay zero
		if (st_q.ap_write && (st_q.ap_sel == SEL_MISC)) begin
			st_d.misc = hwdata & MISC_WMASK;
		end
		if (st_q.ap_write && (st_q.ap_sel == SEL_SGRAM)) begin
			st_d.sgram = hwdata & SGRAM_WMASK;
		end
		// Boot straps land once, just after reset release
		if (strap_load) begin
			st_d.misc[MISC_STRAP_LO +: 5] = strap_val[4:0];
			st_d.sgram[SG_CHIPS]          = strap_val[5];
			st_d.sgram[SG_TYPE]           = strap_val[6];
		end
		// Address phase: latch target and prepare read data
		st_d.ap_write = 1'b0;
		st_d.ap_sel   = SEL_NONE;
		st_d.rdata    = 32'h0000_0000;
		if (take) begin
			st_d.ap_write = hwrite && (hsize == HSIZE_WORD);
			st_d.ap_sel   = sel_dec;
			if (!hwrite && (sel_dec == SEL_MISC)) begin
				st_d.rdata = st_q.misc;
			end else if (!hwrite && (sel_dec == SEL_SGRAM)) begin
				st_d.rdata = st_q.sgram;
			end
		end
		// Write gates toward the PCI config and ROM paths
		st_d.id_en  = board_ident_wr_req && st_q.misc[MISC_IDWR];
		st_d.rom_en = rom_wr_req && st_q.misc[MISC_ROMWR];
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q          <= '0;
			st_q.misc     <= MISC_RST;
			st_q.sgram    <= SGRAM_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// Bus answers: zero wait, always OKAY
	assign hreadyout         = 1'b1;
	assign hresp             = 1'b0;
	assign hrdata            = st_q.rdata;
	assign board_ident_wr_en = st_q.id_en;
	assign rom_wr_en         = st_q.rom_en;

	// ****************************************
	// Control outputs
	// ****************************************
	assign misc_ctrl.inv_clut        = st_q.misc[MISC_INV_CLUT];
	assign misc_ctrl.tri_mode        = st_q.misc[MISC_TRI_LO +: 2];
	assign misc_ctrl.alt_tri_map     = st_q.misc[MISC_ALT_TRI];
	assign misc_ctrl.tex_disable     = st_q.misc[MISC_NO_TEX];
	assign misc_ctrl.power_down      = st_q.misc[MISC_PD_LO +: 5];
	assign misc_ctrl.bw_threshold    = st_q.misc[MISC_BW_LO +: 3];
	assign misc_ctrl.bw_disable      = st_q.misc[MISC_BW_OFF];
	assign misc_ctrl.no_2d_stall     = st_q.misc[MISC_NO2D_STL];
	assign misc_ctrl.no_3d_stall     = st_q.misc[MISC_NO3D_STL];
	assign misc_ctrl.cmd_stream_halt = st_q.misc[MISC_CMD_RST];
	assign misc_ctrl.strap_report    = st_q.misc[MISC_STRAP_LO +: 5];

	// ****************************************
	// SGRAM clock counts
	// ****************************************
	// Each count is the field plus one, registered one cycle later
	mscfg_plus1 #(.W(2)) u_rrd (
		.hclk(hclk), .hresetn(hresetn), .field(st_q.sgram[SG_RRD_LO +: 2]),
		.cnt_q(sgram_timing.row_to_row_delay));
	mscfg_plus1 #(.W(2)) u_rcd (
		.hclk(hclk), .hresetn(hresetn), .field(st_q.sgram[SG_RCD_LO +: 2]),
		.cnt_q(sgram_timing.activate_to_column_delay));
	mscfg_plus1 #(.W(2)) u_rp (
		.hclk(hclk), .hresetn(hresetn), .field(st_q.sgram[SG_RP_LO +: 2]),
		.cnt_q(sgram_timing.precharge_time));
	mscfg_plus1 #(.W(4)) u_ras (
		.hclk(hclk), .hresetn(hresetn), .field(st_q.sgram[SG_RAS_LO +: 4]),
		.cnt_q(sgram_timing.min_row_active_time));
	mscfg_plus1 #(.W(4)) u_rc (
		.hclk(hclk), .hresetn(hresetn), .field(st_q.sgram[SG_RC_LO +: 4]),
		.cnt_q(sgram_timing.min_row_cycle_time));
	mscfg_plus1 #(.W(2)) u_cas (
		.hclk(hclk), .hresetn(hresetn), .field(st_q.sgram[SG_CAS_LO +: 2]),
		.cnt_q(sgram_timing.column_latency));
	mscfg_plus1 #(.W(1)) u_mrs (
		.hclk(hclk), .hresetn(hresetn), .field(st_q.sgram[SG_MRS +: 1]),
		.cnt_q(sgram_timing.mode_reg_cycle_time));
	mscfg_plus1 #(.W(1)) u_bwc (
		.hclk(hclk), .hresetn(hresetn), .field(st_q.sgram[SG_BWC +: 1]),
		.cnt_q(sgram_timing.block_write_cycle_time));
	mscfg_plus1 #(.W(1)) u_wl (
		.hclk(hclk), .hresetn(hresetn), .field(st_q.sgram[SG_WL +: 1]),
		.cnt_q(sgram_timing.write_to_precharge));
	mscfg_plus1 #(.W(2)) u_bwl (
		.hclk(hclk), .hresetn(hresetn), .field(st_q.sgram[SG_BWL_LO +: 2]),
		.cnt_q(sgram_timing.block_write_to_precharge));
	mscfg_plus1 #(.W(1)) u_rl (
		.hclk(hclk), .hresetn(hresetn), .field(st_q.sgram[SG_RL +: 1]),
		.cnt_q(sgram_timing.read_to_precharge));

	// Direct SGRAM option bits
	assign sgram_timing.read_to_mask_delay            = st_q.sgram[SG_DQR];
	assign sgram_timing.reads_end_burst_terminate_cmd = st_q.sgram[SG_BST];
	assign sgram_timing.insert_turnaround             = !st_q.sgram[SG_NO_TURN];
	assign sgram_timing.write_per_bit                 = st_q.sgram[SG_WPB];
	assign sgram_timing.two_chipsets                  = st_q.sgram[SG_CHIPS];
	assign sgram_timing.dense_parts                   = st_q.sgram[SG_TYPE];

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	sequence s_misc_wr;
		take && hwrite && (hsize == HSIZE_WORD) && (sel_dec == SEL_MISC);
	endsequence

	sequence s_sgram_wr;
		take && hwrite && (hsize == HSIZE_WORD) && (sel_dec == SEL_SGRAM);
	endsequence

	// Timing write whose data phase is not overridden by the strap load
	sequence s_sgram_data;
		s_sgram_wr ##1 !strap_load;
	endsequence

	a_ident_block: assert property (
		(board_ident_wr_req && !st_q.misc[MISC_IDWR]) |=> !board_ident_wr_en)
		else $error("ident write passed while disabled");

	a_rom_pass: assert property (
		(rom_wr_req && st_q.misc[MISC_ROMWR]) |=> rom_wr_en)
		else $error("rom write not passed while enabled");

	a_misc_write: assert property (
		s_misc_wr ##1 !strap_load |=> st_q.misc == ($past(hwdata) & MISC_WMASK))
		else $error("misc register write lost");

	a_cmd_halt: assert property (
		s_misc_wr ##1 (hwdata[MISC_CMD_RST] && !strap_load) |=> misc_ctrl.cmd_stream_halt)
		else $error("command halt not raised");

	a_ras_count: assert property (
		s_sgram_data |-> ##2
		(sgram_timing.min_row_active_time == {1'b0, $past(hwdata[SG_RAS_LO +: 4], 2)} + 5'h01))
		else $error("row active count wrong");

	a_cas_count: assert property (
		$stable(st_q.sgram) [*2] |->
		sgram_timing.column_latency == {1'b0, st_q.sgram[SG_CAS_LO +: 2]} + 3'h1)
		else $error("column latency count wrong");

	a_turn_cycle: assert property (
		s_sgram_data |=> sgram_timing.insert_turnaround == !$past(hwdata[SG_NO_TURN]))
		else $error("turnaround option inverted wrongly");

	a_strap_load: assert property (
		strap_load |=> (misc_ctrl.strap_report == $past(strap_val[4:0]))
		&& (sgram_timing.two_chipsets == $past(strap_val[5])))
		else $error("strap values not loaded");

	a_power_down: assert property (
		s_misc_wr ##1 1'b1 |=> misc_ctrl.power_down == $past(hwdata[MISC_PD_LO +: 5]))
		else $error("power down bits wrong");

	a_read_back: assert property (
		(take && !hwrite && (sel_dec == SEL_SGRAM)) |=> hrdata == $past(st_q.sgram))
		else $error("sgram read data wrong");

	// Misc fields follow the word written in the data phase; the strap copies yield to a strap load
	a_clut_invert: assert property (
		s_misc_wr ##1 1'b1 |=> misc_ctrl.inv_clut == $past(hwdata[MISC_INV_CLUT]))
		else $error("colour table invert bit wrong");

	a_tri_mode: assert property (
		s_misc_wr ##1 1'b1 |=> misc_ctrl.tri_mode == $past(hwdata[MISC_TRI_LO +: 2]))
		else $error("triangle mode wrong");

	a_ident_pass: assert property (
		(board_ident_wr_req && st_q.misc[MISC_IDWR]) |=> board_ident_wr_en)
		else $error("ident write not passed while enabled");

	a_rom_block: assert property (
		(rom_wr_req && !st_q.misc[MISC_ROMWR]) |=> !rom_wr_en)
		else $error("rom write passed while disabled");

	a_alt_map: assert property (
		s_misc_wr ##1 1'b1 |=> misc_ctrl.alt_tri_map == $past(hwdata[MISC_ALT_TRI]))
		else $error("alternate map bit wrong");

	a_tex_off: assert property (
		s_misc_wr ##1 1'b1 |=> misc_ctrl.tex_disable == $past(hwdata[MISC_NO_TEX]))
		else $error("texture disable bit wrong");

	a_bw_ctrl: assert property (
		s_misc_wr ##1 1'b1 |=> (misc_ctrl.bw_threshold == $past(hwdata[MISC_BW_LO +: 3]))
		&& (misc_ctrl.bw_disable == $past(hwdata[MISC_BW_OFF])))
		else $error("block write control wrong");

	a_stall_bits: assert property (
		s_misc_wr ##1 1'b1 |=> (misc_ctrl.no_2d_stall == $past(hwdata[MISC_NO2D_STL]))
		&& (misc_ctrl.no_3d_stall == $past(hwdata[MISC_NO3D_STL])))
		else $error("stall bits wrong");

	a_halt_clear: assert property (
		s_misc_wr ##1 !hwdata[MISC_CMD_RST] |=> !misc_ctrl.cmd_stream_halt)
		else $error("command halt not released");

	// Strap copies change only on the boot load or a software write
	a_strap_hold: assert property (
		(!strap_load && !(st_q.ap_write && (st_q.ap_sel == SEL_MISC)))
		|=> $stable(misc_ctrl.strap_report))
		else $error("strap report changed on its own");

	a_strap_dense: assert property (
		strap_load |=> sgram_timing.dense_parts == $past(strap_val[6]))
		else $error("density strap not loaded");

	// Timing counts follow a written field one edge after the write lands
	a_rrd_count: assert property (
		s_sgram_data |-> ##2
		(sgram_timing.row_to_row_delay == {1'b0, $past(hwdata[SG_RRD_LO +: 2], 2)} + 3'h1))
		else $error("row to row count wrong");

	a_rcd_count: assert property (
		s_sgram_data |-> ##2
		(sgram_timing.activate_to_column_delay == {1'b0, $past(hwdata[SG_RCD_LO +: 2], 2)} + 3'h1))
		else $error("activate to column count wrong");

	a_rp_count: assert property (
		s_sgram_data |-> ##2
		(sgram_timing.precharge_time == {1'b0, $past(hwdata[SG_RP_LO +: 2], 2)} + 3'h1))
		else $error("precharge count wrong");

	a_rc_count: assert property (
		s_sgram_data |-> ##2
		(sgram_timing.min_row_cycle_time == {1'b0, $past(hwdata[SG_RC_LO +: 4], 2)} + 5'h01))
		else $error("row cycle count wrong");

	a_cycle_bits: assert property (
		s_sgram_data |-> ##2
		(sgram_timing.mode_reg_cycle_time == {1'b0, $past(hwdata[SG_MRS], 2)} + 2'h1)
		&& (sgram_timing.block_write_cycle_time == {1'b0, $past(hwdata[SG_BWC], 2)} + 2'h1))
		else $error("cycle time counts wrong");

	a_precharge_bits: assert property (
		s_sgram_data |-> ##2
		(sgram_timing.write_to_precharge == {1'b0, $past(hwdata[SG_WL], 2)} + 2'h1)
		&& (sgram_timing.read_to_precharge == {1'b0, $past(hwdata[SG_RL], 2)} + 2'h1))
		else $error("to precharge counts wrong");

	a_mask_delay: assert property (
		s_sgram_data |=> sgram_timing.read_to_mask_delay == $past(hwdata[SG_DQR]))
		else $error("read to mask delay wrong");

	a_bwl_count: assert property (
		s_sgram_data |-> ##2
		(sgram_timing.block_write_to_precharge == {1'b0, $past(hwdata[SG_BWL_LO +: 2], 2)} + 3'h1))
		else $error("block write to precharge count wrong");

	a_bst_option: assert property (
		s_sgram_data |=> sgram_timing.reads_end_burst_terminate_cmd == $past(hwdata[SG_BST]))
		else $error("burst terminate option wrong");

	a_wpb_option: assert property (
		s_sgram_data |=> sgram_timing.write_per_bit == $past(hwdata[SG_WPB]))
		else $error("write per bit option wrong");

endmodule
`default_nettype wire

/* inc/mscfg_pkg.sv */
package mscfg_pkg;

	// ****************************************
	// Register offsets, reset values, masks
	// ****************************************
	localparam logic [7:0]  MISC_OFS    = 8'h14;
	localparam logic [7:0]  SGRAM_OFS   = 8'h18;
	localparam logic [31:0] MISC_RST    = 32'h0000_0000;
	localparam logic [31:0] MISC_WMASK  = 32'h1F0B_FFFF;
	localparam logic [31:0] SGRAM_RST   = 32'h0057_9D29;
	localparam logic [31:0] SGRAM_WMASK = 32'h0FFF_FFFF;
	localparam logic [2:0]  HSIZE_WORD  = 3'h2;
	localparam int          STRAP_W     = 7;

	// ****************************************
	// Miscellaneous control field positions
	// ****************************************
	localparam int MISC_INV_CLUT = 0;
	localparam int MISC_TRI_LO   = 1;
	localparam int MISC_IDWR     = 3;
	localparam int MISC_ROMWR    = 4;
	localparam int MISC_ALT_TRI  = 5;
	localparam int MISC_NO_TEX   = 6;
	localparam int MISC_PD_LO    = 7;
	localparam int MISC_BW_LO    = 12;
	localparam int MISC_BW_OFF   = 15;
	localparam int MISC_NO2D_STL = 16;
	localparam int MISC_NO3D_STL = 17;
	localparam int MISC_CMD_RST  = 19;
	localparam int MISC_STRAP_LO = 24;

	// ****************************************
	// SGRAM timing field positions
	// ****************************************
	localparam int SG_RRD_LO  = 0;
	localparam int SG_RCD_LO  = 2;
	localparam int SG_RP_LO   = 4;
	localparam int SG_RAS_LO  = 6;
	localparam int SG_RC_LO   = 10;
	localparam int SG_CAS_LO  = 14;
	localparam int SG_MRS     = 16;
	localparam int SG_DQR     = 17;
	localparam int SG_BWC     = 18;
	localparam int SG_WL      = 19;
	localparam int SG_BWL_LO  = 20;
	localparam int SG_RL      = 22;
	localparam int SG_BST     = 23;
	localparam int SG_NO_TURN = 24;
	localparam int SG_WPB     = 25;
	localparam int SG_CHIPS   = 26;
	localparam int SG_TYPE    = 27;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic       inv_clut;
		logic [1:0] tri_mode;
		logic       alt_tri_map;
		logic       tex_disable;
		logic [4:0] power_down;
		logic [2:0] bw_threshold;
		logic       bw_disable;
		logic       no_2d_stall;
		logic       no_3d_stall;
		logic       cmd_stream_halt;
		logic [4:0] strap_report;
	} mscfg_misc_t;

	typedef struct packed {
		logic [2:0] row_to_row_delay;
		logic [2:0] activate_to_column_delay;
		logic [2:0] precharge_time;
		logic [4:0] min_row_active_time;
		logic [4:0] min_row_cycle_time;
		logic [2:0] column_latency;
		logic [1:0] mode_reg_cycle_time;
		logic       read_to_mask_delay;
		logic [1:0] block_write_cycle_time;
		logic [1:0] write_to_precharge;
		logic [2:0] block_write_to_precharge;
		logic [1:0] read_to_precharge;
		logic       reads_end_burst_terminate_cmd;
		logic       insert_turnaround;
		logic       write_per_bit;
		logic       two_chipsets;
		logic       dense_parts;
	} mscfg_sgram_t;

	typedef struct packed {
		logic               done;
		logic               load;
		logic [STRAP_W-1:0] val;
	} mscfg_strap_st_t;

endpackage

/* design/mscfg_plus1.sv */
`timescale 1ns/1ps
`default_nettype none
// Registered clock count equal to a timing field plus one
module mscfg_plus1
	import mscfg_pkg::*;
#(
	parameter int W = 2
) (
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic [W-1:0] field,
	output var  logic [W:0]   cnt_q
);

	logic [W:0] cnt_d;

	// Widen before adding so the top value does not wrap
	always_comb begin
		cnt_d = {1'b0, field} + {{W{1'b0}}, 1'b1};
	end

	// Count register, one cycle behind the field
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= {{W{1'b0}}, 1'b1};
		end else begin
			cnt_q <= cnt_d;
		end
	end

endmodule
`default_nettype wire

/* design/mscfg_strap.sv */
`timescale 1ns/1ps
`default_nettype none
// Samples the strap pins once, at the first edge after reset release
module mscfg_strap
	import mscfg_pkg::*;
(
	input  wire logic               hclk,
	input  wire logic               hresetn,
	input  wire logic [STRAP_W-1:0] strap_in,
	output var  logic [STRAP_W-1:0] strap_q,
	output var  logic               load_q
);

	mscfg_strap_st_t st_q;
	mscfg_strap_st_t st_d;

	// Capture once; afterwards the value is held and load drops
	always_comb begin
		st_d      = st_q;
		st_d.load = 1'b0;
		if (!st_q.done) begin
			st_d.val  = strap_in;
			st_d.done = 1'b1;
			st_d.load = 1'b1;
		end
	end

	// Reset takes constants only; pins are read by the clocked path
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign strap_q = st_q.val;
	assign load_q  = st_q.load;

endmodule
`default_nettype wire

/* design/HANDOVER_end.sv */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import mscfg_pkg::*;
;
	logic               hclk;
	logic               hresetn;
	logic               hsel;
	logic               hwrite;
	logic [31:0]        haddr;
	logic [31:0]        hwdata;
	logic [31:0]        hrdata;
	logic [1:0]         htrans;
	logic [2:0]         hsize;
	logic               hreadyout;
	logic               hresp;
	logic [STRAP_W-1:0] strap;
	logic               id_req;
	logic               rom_req;
	logic               id_en;
	logic               rom_en;
	mscfg_misc_t        misc_ctrl;
	mscfg_sgram_t       sg_tim;
	logic               rd_ph;
	logic               g_chk;
	logic [31:0]        lfsr_q;
	logic [31:0]        rq[$];
	logic [1:0]         gq[$];
	int                 num_errors;
	int                 checks_done;

	mscfg_regs dut_u (
		.hclk               (hclk),
		.hresetn            (hresetn),
		.hsel               (hsel),
		.haddr              (haddr),
		.htrans             (htrans),
		.hwrite             (hwrite),
		.hsize              (hsize),
		.hwdata             (hwdata),
		.hready             (hreadyout),
		.hreadyout          (hreadyout),
		.hresp              (hresp),
		.hrdata             (hrdata),
		.strap_data_input   (strap),
		.board_ident_wr_req (id_req),
		.rom_wr_req         (rom_req),
		.board_ident_wr_en  (id_en),
		.rom_wr_en          (rom_en),
		.misc_ctrl          (misc_ctrl),
		.sgram_timing       (sg_tim)
	);

	// Free-running bus clock
	always #5 hclk = ~hclk;

	// ****************************************
	// Checking and verdict
	// ****************************************
	task give_verdict();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task cmp_word(input logic [63:0] got, input logic [63:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task cmp_gate(input logic [1:0] got, input logic [1:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: enables got %b exp %b", $time, got, exp);
		end
	endtask

	// Takes the oldest note whenever a read or gate result stands
	always @(posedge hclk) begin
		if (rd_ph === 1'b1 && rq.size() > 0) begin
			cmp_word({32'h0, hrdata}, {32'h0, rq.pop_front()}, "read data");
			cmp_word({63'h0, hresp}, 64'h0, "response");
		end
		if (g_chk === 1'b1 && gq.size() > 0)
			cmp_gate({rom_en, id_en}, gq.pop_front());
	end

	// Expected decoded outputs for a given register word
	function automatic logic [63:0] misc_exp(input logic [31:0] r);
		return {42'h0, r[0], r[2:1], r[5], r[6], r[11:7], r[14:12], r[15], r[16], r[17],
			r[19], r[28:24]};
	endfunction

	function automatic logic [63:0] sg_exp(input logic [31:0] r);
		return {25'h0, 3'(r[1:0]) + 3'h1, 3'(r[3:2]) + 3'h1, 3'(r[5:4]) + 3'h1,
			5'(r[9:6]) + 5'h01, 5'(r[13:10]) + 5'h01, 3'(r[15:14]) + 3'h1,
			2'(r[16]) + 2'h1, r[17], 2'(r[18]) + 2'h1, 2'(r[19]) + 2'h1,
			3'(r[21:20]) + 3'h1, 2'(r[22]) + 2'h1, r[23], ~r[24], r[25], r[26], r[27]};
	endfunction

	// ****************************************
	// Stimulus tasks
	// ****************************************
	// Next state of the stimulus shift register
	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	task rnd(output logic [31:0] r);
		lfsr_q = lfsr_next(lfsr_q);
		r = lfsr_q;
	endtask

	task wait_rdy();
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1 && n < 50) begin
			n++;
			@(posedge hclk);
		end
		if (n >= 50) begin
			num_errors++;
			give_verdict();
		end
	endtask

	task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
		input logic [2:0] sz, input logic [31:0] exp);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= a;
		hsize <= sz;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		if (!wr) begin
			rq.push_back(exp);
			rd_ph <= 1'b1;
		end
		wait_rdy();
		rd_ph <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		ahb(1'b1, {24'h0, a}, d, HSIZE_WORD, 32'h0);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] exp);
		ahb(1'b0, {24'h0, a}, 32'h0, HSIZE_WORD, exp);
	endtask

	task gate(input logic id, input logic rom, input logic [1:0] exp);
		id_req <= id;
		rom_req <= rom;
		@(posedge hclk);
		id_req <= 1'b0;
		rom_req <= 1'b0;
		gq.push_back(exp);
		g_chk <= 1'b1;
		@(posedge hclk);
		g_chk <= 1'b0;
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		logic [31:0] r;
		logic [31:0] s;
		{hclk, hsel, hwrite, id_req, rom_req, rd_ph, g_chk} = '0;
		{haddr, hwdata, htrans} = '0;
		hsize = HSIZE_WORD;
		hresetn = 1'b0;
		num_errors = 0;
		checks_done = 0;
		lfsr_q = 32'd61;
		rnd(r);
		strap = r[6:0];
		for (int k = 0; k < 2; k++) begin
			repeat (3) @(posedge hclk);
			hresetn <= 1'b1;
			repeat (3) @(posedge hclk);
			rd(MISC_OFS, {3'h0, strap[4:0], 24'h0});
			s = {4'h0, strap[6:5], SGRAM_RST[25:0]};
			rd(SGRAM_OFS, s);
			cmp_word({25'h0, sg_tim}, sg_exp(s), "timing at reset");
			// Second pass runs through a mid-run reset with new strap levels
			if (k == 0) begin
				rnd(r);
				hresetn <= 1'b0;
				strap <= r[6:0];
			end
		end
		$display("test reset values done");
		for (int i = 0; i < 8; i++) begin
			rnd(r);
			rnd(s);
			if (i == 0) {r, s} = '1;
			if (i == 1) {r, s} = '0;
			wr(MISC_OFS, r);
			wr(SGRAM_OFS, s);
			rd(MISC_OFS, r & MISC_WMASK);
			rd(SGRAM_OFS, s & SGRAM_WMASK);
			cmp_word({42'h0, misc_ctrl}, misc_exp(r), "misc fields");
			cmp_word({25'h0, sg_tim}, sg_exp(s), "timing fields");
		end
		wr(MISC_OFS, 32'h0);
		$display("test field decode done");
		wr(8'h1C, 32'hFFFF_FFFF);
		rd(8'h1C, 32'h0);
		ahb(1'b1, {24'h0, MISC_OFS}, 32'hFFFF_FFFF, 3'h1, 32'h0);
		rd(MISC_OFS, 32'h0);
		$display("test refusals done");
		for (int b = 0; b < 4; b++) begin
			wr(MISC_OFS, 32'(b) << 3);
			gate(1'b1, 1'b1, 2'(b));
			gate(1'b0, 1'b0, 2'h0);
		end
		$display("test write gates done");
		give_verdict();
	end
endmodule
`default_nettype wire
